// *** design/timer8_defs.vh ***
// register map, field positions and reset values of the 8-bit waveform timer
`ifndef TIMER8_DEFS_VH
`define TIMER8_DEFS_VH
// ---------------------------------------------------------------
// register indices
// ---------------------------------------------------------------
`define ADDR_CTRL_A 3'h0
`define ADDR_CTRL_B 3'h1
`define ADDR_COUNT 3'h2
`define ADDR_CMP_A 3'h3
`define ADDR_CMP_B 3'h4
`define ADDR_FLAGS 3'h5
`define ADDR_PINCFG 3'h6
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CA_COMA_HI 7
`define CA_COMA_LO 6
`define CA_COMB_HI 5
`define CA_COMB_LO 4
`define CA_WGM_HI 1
`define CA_WGM_LO 0
`define CB_FOCA 7
`define CB_FOCB 6
`define CB_WGM2 3
`define CB_CS_HI 2
`define CB_CS_LO 0
`define FL_OVF 0
`define FL_CMPA 1
`define FL_CMPB 2
`define PC_DIR_A 0
`define PC_DIR_B 1
// ---------------------------------------------------------------
// reset values and constants
// ---------------------------------------------------------------
`define RST_BYTE 8'h00
`define CNT_MAX 8'hFF
`define CNT_BOTTOM 8'h00
`define CA_RD_MASK 8'hF3
`define CB_RD_MASK 8'h0F
`endif

// *** design/timer8_waveform_compare_unit.v ***
// 8-bit timer/counter with two compare channels and waveform outputs
//
// Notes on behaviour
// - nonzero output mode routes compare-B to pin, except code 01 in PWM
// - pin driven only with direction bit set
// - non-PWM modes: off, toggle, clear, set
// - fast PWM: clear/set on match, inverse at bottom
// - fast PWM: match at TOP ignored, bottom acts
// - phase PWM: up-match and down-match act oppositely
// - phase PWM: match at TOP ignored, TOP acts
// - waveform mode code selects counting mode
// - TOP is 0xFF or compare-A value
// - compare buffer update point and overflow point
// - force bit strobes a match onto output
// - forced match sets no flag, no clear
// - force and reserved bits read zero
// - clock select: stop, /1, /8 ... /1024
// - counter readable, write blocks next match
// - compare registers compared against counter continuously
// - compare flags set on match, clear by ack/one
// - overflow flag clears by ack or one written
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "timer8_defs.vh"

// ---------------------------------------------------------------
// operating notes
// ---------------------------------------------------------------
// counting
// - one timer step per prescaler tick, never per bus cycle
// - the prescaler runs free from reset and is not cleared
//   when the clock select changes, so the first tick after
//   a select write can come anywhere inside one divide period
// - a stopped timer (select zero) still accepts bus writes
// - reserved waveform codes 4 and 6 fall back to normal mode
//   rather than freezing, so a stray code cannot stall the count
//
// compare path
// - the compare is made against the count before the step,
//   which keeps match and flag in the same tick
// - a counter write masks the match of the next tick only;
//   ticks in between do not extend the mask
// - in the pwm modes the compare values are double buffered;
//   reads return the buffer, not the value in use
// - a buffer write in the cycle of the update point is taken
//   straight from the bus so it is not lost for a period
//
// waveform path
// - both channels share one next-state function; channel b
//   has no toggle in pwm, channel a needs the high mode bit
// - a compare value at top in fast pwm gives a constant level
//   set by the bottom action alone
// - in phase pwm a compare value at top acts at the turn
//   from up to down counting
// - forced matches act only in the non-pwm modes and leave
//   flags and counter untouched
//
// flags
// - a hardware set in the same cycle as a clear wins, so an
//   event is never lost to a late acknowledge
// - write one clears; writing zero leaves a flag alone
//
// bus
// - reads are answered one cycle later and the data word is
//   zero in every other cycle, so an or-tree can merge ports
// - reads are served while the clock enable is low, but no
//   state moves then
//
// pins
// - override follows the output and waveform modes alone; the drive enable
//   also needs the direction bit of that pin
// - the reserved pwm code on channel b leaves the pin with
//   the port function
//
// limits
// - no asynchronous source; the source clock is the main
//   clock gated by the enable
// - no prescaler reset strobe
//

module timer8_waveform_compare_unit #(
    parameter WIDTH = 8
) (
    // clock, reset, enable
    input wire mclk_i,
    input wire srst_i,
    input wire ce_i,
    // register port
    input wire [2:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    // interrupt acknowledge from vector fetch
    input wire ack_ovf_i,
    input wire ack_cmpa_i,
    input wire ack_cmpb_i,
    // flags towards the interrupt controller
    output wire ovf_flag_o,
    output wire cmpa_flag_o,
    output wire cmpb_flag_o,
    // compare pins
    output wire compare_a_pin_o,
    output wire compare_a_pin_oe_o,
    output wire compare_a_override_o,
    output wire compare_b_pin_o,
    output wire compare_b_pin_oe_o,
    output wire compare_b_override_o
);

// ---------------------------------------------------------------
// registers
// ---------------------------------------------------------------
reg [7:0] ctrl_a_r;
reg [3:0] ctrl_b_r;
reg [WIDTH-1:0] count_r;
reg [WIDTH-1:0] cmp_a_buf_r;
reg [WIDTH-1:0] cmp_b_buf_r;
reg [WIDTH-1:0] cmp_a_r;
reg [WIDTH-1:0] cmp_b_r;
reg [2:0] flags_r;
reg [1:0] dir_r;
reg down_r;
reg block_r;
reg wave_a_r;
reg wave_b_r;
reg [9:0] presc_r;

wire [2:0] wgm = {ctrl_b_r[`CB_WGM2], ctrl_a_r[`CA_WGM_HI:`CA_WGM_LO]};
wire [2:0] cs = ctrl_b_r[`CB_CS_HI:`CB_CS_LO];
wire [1:0] com_a = ctrl_a_r[`CA_COMA_HI:`CA_COMA_LO];
wire [1:0] com_b = ctrl_a_r[`CA_COMB_HI:`CA_COMB_LO];

// ---------------------------------------------------------------
// mode decode
// ---------------------------------------------------------------
// reserved codes 4 and 6 behave as normal mode
wire is_phase = (wgm == 3'h1) || (wgm == 3'h5);
wire is_fast = (wgm == 3'h3) || (wgm == 3'h7);
wire is_pwm = is_phase || is_fast;
wire top_is_a = (wgm == 3'h2) || (wgm == 3'h5) || (wgm == 3'h7);
wire [WIDTH-1:0] top = top_is_a ? cmp_a_r : {WIDTH{1'b1}};

// ---------------------------------------------------------------
// prescaler tick
// ---------------------------------------------------------------
// free running divider; taps for /8 up to /1024
function tap_tick;
    input [2:0] sel;
    input [9:0] p;
    begin
        case (sel)
            3'h1: tap_tick = 1'b1;
            3'h2: tap_tick = (p[2:0] == 3'h7);
            3'h3: tap_tick = (p[4:0] == 5'h1F);
            3'h4: tap_tick = (p[5:0] == 6'h3F);
            3'h5: tap_tick = (p[6:0] == 7'h7F);
            3'h6: tap_tick = (p[7:0] == 8'hFF);
            3'h7: tap_tick = (p == 10'h3FF);
            default: tap_tick = 1'b0;
        endcase
    end
endfunction

wire tick = ce_i && tap_tick(cs, presc_r);

// ---------------------------------------------------------------
// compare and sequence
// ---------------------------------------------------------------
wire match_a = tick && !block_r && (count_r == cmp_a_r);
wire match_b = tick && !block_r && (count_r == cmp_b_r);
wire at_top = (count_r == top);
wire at_bottom = (count_r == {WIDTH{1'b0}});
wire cnt_wr = wr_i && (addr_i == `ADDR_COUNT);
wire cb_wr = wr_i && (addr_i == `ADDR_CTRL_B);
wire force_a = ce_i && cb_wr && wdata_i[`CB_FOCA] && !is_pwm;
wire force_b = ce_i && cb_wr && wdata_i[`CB_FOCB] && !is_pwm;

// next count and direction
reg [WIDTH-1:0] count_nxt;
reg down_nxt;
reg ovf_evt;
reg upd_evt;
always @* begin
    count_nxt = count_r;
    down_nxt = down_r;
    ovf_evt = 1'b0;
    upd_evt = !is_pwm;
    if (tick) begin
        if (is_phase) begin
            if (!down_r && at_top) begin
                down_nxt = 1'b1;
                count_nxt = count_r - 1'b1;
                upd_evt = 1'b1;
            end else if (down_r && at_bottom) begin
                down_nxt = 1'b0;
                count_nxt = count_r + 1'b1;
                ovf_evt = 1'b1;
            end else if (down_r) begin
                count_nxt = count_r - 1'b1;
            end else begin
                count_nxt = count_r + 1'b1;
            end
        end else begin
            down_nxt = 1'b0;
            if (at_top) begin
                count_nxt = {WIDTH{1'b0}};
            end else begin
                count_nxt = count_r + 1'b1;
            end
            if (is_fast && at_top) begin
                upd_evt = 1'b1;
            end
            // mode 7 flags at TOP, others at MAX
            if ((wgm == 3'h7) ? at_top : (count_r == {WIDTH{1'b1}})) begin
                ovf_evt = 1'b1;
            end
        end
    end
end

// ---------------------------------------------------------------
// output waveform next value
// ---------------------------------------------------------------
// shared for both channels; is_top_cmp means compare value equals TOP
function wave_next;
    input cur;
    input [1:0] com;
    input m;
    input frc;
    input is_top_cmp;
    input fast;
    input phase;
    input dn;
    input bot;
    input tp;
    input tk;
    input is_a;
    begin
        wave_next = cur;
        if (fast) begin
            // match at TOP is skipped, bottom still acts
            if (com[1] && m && !is_top_cmp) begin
                wave_next = com[0];
            end
            if (com[1] && tk && tp) begin
                wave_next = !com[0];
            end
            if (is_a && com == 2'h1 && m) begin
                wave_next = !cur;
            end
        end else if (phase) begin
            // match at TOP ignored, the action happens at TOP
            if (com[1] && m && !is_top_cmp) begin
                wave_next = dn ? !com[0] : com[0];
            end
            if (com[1] && is_top_cmp && tk && tp && !dn) begin
                wave_next = com[0];
            end
            if (is_a && com == 2'h1 && m) begin
                wave_next = !cur;
            end
        end else if (m || frc) begin
            case (com)
                2'h1: wave_next = !cur;
                2'h2: wave_next = 1'b0;
                2'h3: wave_next = 1'b1;
                default: wave_next = cur;
            endcase
        end
    end
endfunction

// toggle in PWM for channel A needs the high mode bit
wire a_tog_ok = ctrl_b_r[`CB_WGM2];
wire wave_a_nxt = wave_next(wave_a_r, com_a, match_a, force_a, cmp_a_r == top, is_fast, is_phase,
    down_r, at_bottom, at_top, tick, a_tog_ok);
wire wave_b_nxt = wave_next(wave_b_r, com_b, match_b, force_b, cmp_b_r == top, is_fast, is_phase,
    down_r, at_bottom, at_top, tick, 1'b0);

// ---------------------------------------------------------------
// state update
// ---------------------------------------------------------------
always @(posedge mclk_i) begin
    if (srst_i) begin
        ctrl_a_r <= `RST_BYTE;
        ctrl_b_r <= 4'h0;
        count_r <= `RST_BYTE;
        cmp_a_buf_r <= `RST_BYTE;
        cmp_b_buf_r <= `RST_BYTE;
        cmp_a_r <= `RST_BYTE;
        cmp_b_r <= `RST_BYTE;
        flags_r <= 3'h0;
        dir_r <= 2'h0;
        down_r <= 1'b0;
        block_r <= 1'b0;
        wave_a_r <= 1'b0;
        wave_b_r <= 1'b0;
        presc_r <= 10'h000;
    end else if (ce_i) begin
        presc_r <= presc_r + 10'h001;
        down_r <= down_nxt;
        wave_a_r <= wave_a_nxt;
        wave_b_r <= wave_b_nxt;
        // a counter write blocks the match on the next tick
        if (cnt_wr) begin
            count_r <= wdata_i;
            block_r <= 1'b1;
        end else begin
            count_r <= count_nxt;
            if (tick) begin
                block_r <= 1'b0;
            end
        end
        // buffered compare values load at the update point
        if (upd_evt) begin
            cmp_a_r <= (wr_i && addr_i == `ADDR_CMP_A) ? wdata_i : cmp_a_buf_r;
            cmp_b_r <= (wr_i && addr_i == `ADDR_CMP_B) ? wdata_i : cmp_b_buf_r;
        end
        // flags: hardware set wins over any clear; forced match sets nothing
        flags_r[`FL_OVF] <= ovf_evt ||
            (flags_r[`FL_OVF] && !ack_ovf_i && !(wr_i && addr_i == `ADDR_FLAGS && wdata_i[`FL_OVF]));
        flags_r[`FL_CMPA] <= match_a ||
            (flags_r[`FL_CMPA] && !ack_cmpa_i && !(wr_i && addr_i == `ADDR_FLAGS && wdata_i[`FL_CMPA]));
        flags_r[`FL_CMPB] <= match_b ||
            (flags_r[`FL_CMPB] && !ack_cmpb_i && !(wr_i && addr_i == `ADDR_FLAGS && wdata_i[`FL_CMPB]));
        if (wr_i) begin
            case (addr_i)
                `ADDR_CTRL_A: ctrl_a_r <= wdata_i & `CA_RD_MASK;
                `ADDR_CTRL_B: ctrl_b_r <= wdata_i[3:0];
                `ADDR_CMP_A: cmp_a_buf_r <= wdata_i;
                `ADDR_CMP_B: cmp_b_buf_r <= wdata_i;
                `ADDR_PINCFG: dir_r <= wdata_i[1:0];
                default: dir_r <= dir_r;
            endcase
        end
    end
end

// ---------------------------------------------------------------
// read port
// ---------------------------------------------------------------
// data stands one cycle after the strobe, zero otherwise
always @(posedge mclk_i) begin
    if (srst_i) begin
        rdata_o <= 8'h00;
    end else if (rd_i) begin
        case (addr_i)
            `ADDR_CTRL_A: rdata_o <= ctrl_a_r & `CA_RD_MASK;
            `ADDR_CTRL_B: rdata_o <= {4'h0, ctrl_b_r};
            `ADDR_COUNT: rdata_o <= count_r;
            `ADDR_CMP_A: rdata_o <= cmp_a_buf_r;
            `ADDR_CMP_B: rdata_o <= cmp_b_buf_r;
            `ADDR_FLAGS: rdata_o <= {5'h00, flags_r};
            `ADDR_PINCFG: rdata_o <= {6'h00, dir_r};
            default: rdata_o <= 8'h00;
        endcase
    end else begin
        rdata_o <= 8'h00;
    end
end

// ---------------------------------------------------------------
// pins
// ---------------------------------------------------------------
// fast/phase code 01 on channel B is reserved and leaves the pin with the port
wire b_conn = (com_b != 2'h0) && !(is_pwm && com_b == 2'h1);
assign compare_b_override_o = b_conn;
assign compare_b_pin_oe_o = b_conn && dir_r[`PC_DIR_B];
assign compare_b_pin_o = wave_b_r;
assign compare_a_override_o = (com_a != 2'h0) && !(is_pwm && com_a == 2'h1 && !a_tog_ok);
assign compare_a_pin_oe_o = compare_a_override_o && dir_r[`PC_DIR_A];
assign compare_a_pin_o = wave_a_r;
assign ovf_flag_o = flags_r[`FL_OVF];
assign cmpa_flag_o = flags_r[`FL_CMPA];
assign cmpb_flag_o = flags_r[`FL_CMPB];

endmodule

// *** dv/tb_timer8_waveform_compare_unit.sv ***
// self-checking bench for the 8-bit waveform timer
`timescale 1ns/1ns
`include "timer8_defs.vh"
`define CHK(g, e) begin checks = checks + 1; if ((g) !== (e)) begin mismatches = mismatches + 1; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_timer8_waveform_compare_unit;
    // ----------------------------
    // stimulus and dut
    // ----------------------------
    reg mclk_i = 0, srst_i = 1, ce_i = 1, wr_i = 0, rd_i = 0;
    reg ack_ovf_i = 0, ack_cmpa_i = 0, ack_cmpb_i = 0;
    reg [2:0] addr_i = 3'h0;
    reg [7:0] wdata_i = 8'h00, v;
    wire [7:0] rdata_o;
    wire ovf_flag_o, cmpa_flag_o, cmpb_flag_o, compare_a_pin_o, compare_a_pin_oe_o, compare_a_override_o;
    wire compare_b_pin_o, compare_b_pin_oe_o, compare_b_override_o;
    integer mismatches = 0, checks = 0, cyc = 0, n, c;
    integer dv [1:7] = '{1, 8, 32, 64, 128, 256, 1024};
    timer8_waveform_compare_unit dut (.mclk_i, .srst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .ack_ovf_i, .ack_cmpa_i, .ack_cmpb_i, .ovf_flag_o, .cmpa_flag_o, .cmpb_flag_o, .compare_a_pin_o,
        .compare_a_pin_oe_o, .compare_a_override_o, .compare_b_pin_o, .compare_b_pin_oe_o,
        .compare_b_override_o);
    // clock, and a guard so a hang still ends in the report
    always #50 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            mismatches = mismatches + 1;
            results;
        end
    end
    // ----------------------------
    // bus tasks
    // ----------------------------
    task wr(input [2:0] a, input [7:0] d); begin
        @(posedge mclk_i) {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
        @(posedge mclk_i) wr_i <= 0;
    end endtask
    // read data is looked at mid-cycle, in its only valid cycle
    task chk(input [2:0] a, input [7:0] e); begin
        @(posedge mclk_i) {addr_i, rd_i} <= {a, 1'b1};
        @(posedge mclk_i) rd_i <= 0;
        @(negedge mclk_i) v = rdata_o;
        `CHK(v, e)
    end endtask
    // counts high cycles of pin b over whole pwm periods
    task duty(input [7:0] ca, cb, ta, tb, input integer len, lo, hi); begin
        wr(`ADDR_CMP_A, ta);
        wr(`ADDR_CMP_B, tb);
        wr(`ADDR_CTRL_A, ca);
        wr(`ADDR_CTRL_B, cb);
        repeat (520) @(posedge mclk_i);
        n = 0;
        repeat (len) @(negedge mclk_i) n = n + compare_b_pin_o;
        `CHK(n >= lo && n <= hi, 1'b1)
    end endtask
    task results; begin
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    end endtask
    // ----------------------------
    // scenarios
    // ----------------------------
    task t_regs; begin
        wr(`ADDR_CTRL_A, 8'hFF);
        chk(`ADDR_CTRL_A, 8'hF3);
        wr(`ADDR_CTRL_A, 8'h00);
        wr(`ADDR_CTRL_B, 8'hF0);
        chk(`ADDR_CTRL_B, 8'h00);
        chk(3'h7, 8'h00);
        wr(`ADDR_COUNT, 8'h5A);
        repeat (5) @(posedge mclk_i);
        chk(`ADDR_COUNT, 8'h5A);
    end endtask
    task t_force; begin
        wr(`ADDR_PINCFG, 8'h02);
        for (c = 1; c < 4; c = c + 1) begin
            wr(`ADDR_CTRL_A, c << 4);
            @(negedge mclk_i) v = {7'h00, compare_b_pin_o};
            `CHK({compare_b_override_o, compare_b_pin_oe_o}, 2'b11)
            wr(`ADDR_CTRL_B, 8'h40);
            @(negedge mclk_i);
            `CHK(compare_b_pin_o, c == 1 ? ~v[0] : c == 3)
        end
        // channel a: route, drive and forced toggle
        wr(`ADDR_PINCFG, 8'h01);
        wr(`ADDR_CTRL_A, 8'h40);
        @(negedge mclk_i) v = {7'h00, compare_a_pin_o};
        `CHK({compare_a_override_o, compare_a_pin_oe_o}, 2'b11)
        wr(`ADDR_CTRL_B, 8'h80);
        @(negedge mclk_i);
        `CHK(compare_a_pin_o, ~v[0])
        `CHK(cmpa_flag_o, 1'b0)
        `CHK(cmpb_flag_o, 1'b0)
        chk(`ADDR_COUNT, 8'h5A);
        wr(`ADDR_PINCFG, 8'h00);
        @(negedge mclk_i);
        `CHK(compare_b_pin_oe_o, 1'b0)
    end endtask
    task t_count; begin
        for (c = 1; c < 8; c = c + 1) begin
            wr(`ADDR_CTRL_B, 8'h00);
            wr(`ADDR_COUNT, 8'h00);
            wr(`ADDR_CTRL_B, c);
            // window of exactly 4 divide periods: phase of the free prescaler drops out
            repeat (4 * dv[c] - 2) @(posedge mclk_i);
            wr(`ADDR_CTRL_B, 8'h00);
            chk(`ADDR_COUNT, 8'h04);
            `CHK(v >= 3 && v <= 6, 1'b1)
        end
    end endtask
    task t_match; begin
        // force the pin low first so the set on match is visible
        wr(`ADDR_CTRL_A, 8'h20);
        wr(`ADDR_CTRL_B, 8'h40);
        @(negedge mclk_i);
        `CHK(compare_b_pin_o, 1'b0)
        wr(`ADDR_CTRL_A, 8'h30);
        wr(`ADDR_CMP_B, 8'h10);
        wr(`ADDR_COUNT, 8'h0C);
        wr(`ADDR_FLAGS, 8'h07);
        wr(`ADDR_CTRL_B, 8'h01);
        repeat (8) @(posedge mclk_i);
        `CHK({cmpb_flag_o, compare_b_pin_o}, 2'b11)
        @(posedge mclk_i) ack_cmpb_i <= 1;
        @(posedge mclk_i) ack_cmpb_i <= 0;
        wr(`ADDR_CMP_B, 8'h20);
        `CHK(cmpb_flag_o, 1'b0)
        wr(`ADDR_COUNT, 8'h20);
        repeat (4) @(posedge mclk_i);
        `CHK(cmpb_flag_o, 1'b0)
        wr(`ADDR_COUNT, 8'hFD);
        repeat (6) @(posedge mclk_i);
        `CHK(ovf_flag_o, 1'b1)
        wr(`ADDR_FLAGS, 8'h01);
        @(negedge mclk_i);
        `CHK(ovf_flag_o, 1'b0)
        wr(`ADDR_CTRL_A, 8'h02);
        wr(`ADDR_CMP_A, 8'h09);
        repeat (40) @(posedge mclk_i);
        `CHK({ovf_flag_o, cmpa_flag_o}, 2'b01)
        wr(`ADDR_CTRL_B, 8'h00);
        // 41 steps after the first wrap at top 9
        chk(`ADDR_COUNT, 8'h01);
        `CHK(v <= 8'h09, 1'b1)
        @(posedge mclk_i) ack_cmpa_i <= 1;
        @(posedge mclk_i) ack_cmpa_i <= 0;
        @(negedge mclk_i);
        `CHK(cmpa_flag_o, 1'b0)
    end endtask
    task t_pwm; begin
        duty(8'h23, 8'h01, 8'h00, 8'h80, 512, 256, 260);
        duty(8'h33, 8'h01, 8'h00, 8'h80, 512, 252, 256);
        duty(8'h23, 8'h01, 8'h00, 8'hFF, 512, 511, 512);
        duty(8'h23, 8'h09, 8'h3F, 8'h10, 512, 134, 138);
        wr(`ADDR_FLAGS, 8'h07);
        duty(8'h21, 8'h01, 8'h00, 8'h40, 510, 124, 132);
        `CHK(ovf_flag_o, 1'b1)
        duty(8'h21, 8'h01, 8'h00, 8'hFF, 510, 0, 1);
        duty(8'h31, 8'h01, 8'h00, 8'hFF, 510, 509, 510);
        duty(8'h21, 8'h09, 8'h3F, 8'h10, 504, 124, 132);
        // reserved pwm code on channel b keeps the port function
        wr(`ADDR_CTRL_A, 8'h13);
        @(negedge mclk_i);
        `CHK(compare_b_override_o, 1'b0)
    end endtask
    // reset for 8 cycles, then the scenarios in turn
    initial begin
        repeat (8) @(posedge mclk_i);
        srst_i <= 0;
        t_regs;
        t_force;
        t_count;
        t_match;
        t_pwm;
        results;
    end
endmodule

// *** dv/timer8_chk.sv ***
// concurrent checks on the ports of the 8-bit waveform timer
`timescale 1ns/1ns
`include "timer8_defs.vh"
module timer8_chk (
    // clock, reset, enable
    input wire mclk_i,
    input wire srst_i,
    input wire ce_i,
    // register port
    input wire [2:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    // compare-b pin
    input wire compare_b_pin_o,
    input wire compare_b_pin_oe_o,
    input wire compare_b_override_o
);
    // ----------------------------
    // shadow of control a
    // ----------------------------
    reg [7:0] ca_r;
    wire wa = wr_i && ce_i && addr_i == `ADDR_CTRL_A;
    // force only acts in even waveform codes, i.e. the non-pwm ones
    wire fb = wr_i && ce_i && addr_i == `ADDR_CTRL_B && wdata_i[`CB_FOCB] && !ca_r[0];
    wire wp = wr_i && ce_i && addr_i == `ADDR_PINCFG;
    // shadow follows every accepted write to control a
    always @(posedge mclk_i) begin
        if (srst_i) begin
            ca_r <= 8'h00;
        end else if (wa) begin
            ca_r <= wdata_i;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    chk_oe_needs_route:
        assert property (compare_b_pin_oe_o |-> compare_b_override_o) else $error("pin b driven unrouted");
    chk_dir_off:
        assert property (wp && !wdata_i[1] |=> !compare_b_pin_oe_o) else $error("pin b driven without dir");
    chk_route_on:
        assert property (wa && wdata_i[5] |=> compare_b_override_o) else $error("pin b not routed");
    chk_route_off:
        assert property (wa && wdata_i[5:4] == 2'h0 |=> !compare_b_override_o) else $error("pin b routed");
    chk_force_toggle:
        assert property (fb && ca_r[5:4] == 2'h1 |=> compare_b_pin_o != $past(compare_b_pin_o))
        else $error("forced toggle missing");
    chk_force_level:
        assert property (fb && ca_r[5] |=> compare_b_pin_o == $past(ca_r[4])) else $error("forced level wrong");
    chk_ctrl_a_read:
        assert property (rd_i && addr_i == `ADDR_CTRL_A |=> rdata_o == ($past(ca_r) & `CA_RD_MASK))
        else $error("control a readback wrong");
    chk_ctrl_b_rsvd:
        assert property (rd_i && addr_i == `ADDR_CTRL_B |=> rdata_o[7:4] == 4'h0) else $error("control b high bits");
    chk_idle_rdata:
        assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data without read");
    cov_force: cover property (fb);
    cov_route: cover property ($rose(compare_b_override_o));
    cov_drive: cover property ($rose(compare_b_pin_oe_o));
endmodule
bind timer8_waveform_compare_unit timer8_chk u_chk (.mclk_i, .srst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .compare_b_pin_o, .compare_b_pin_oe_o, .compare_b_override_o);
